// >>> hw/qdh_decode.sv
// Address and strobe decoder that produces the per-channel select requests.
`timescale 1ns/1ps
module qdh_decode (
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    output logic [3:0] sel_out,
    output logic match_out
);
    wire base_hit;
    assign base_hit = addr_in[15:qdh_pkg::BASE_LSB] == qdh_pkg::BASE_ADDR;
    // Only a write to the base block may raise any select.
    assign match_out = base_hit;
    assign sel_out = (wr_in && base_hit) ? addr_in[3:qdh_pkg::SEL_LSB] : 4'h0;
endmodule : qdh_decode

// >>> hw/qdh_host.sv
// Host controller that loads four DAC channels and runs a software-style SAR conversion.
//
// Function
// - One address bit selects each DAC.
// - Bus selects only with write and base match.
// - Several selects share one bus word.
// - Select bits start at word address.
// - Sixteen-bit word, left or right justified.
// - Byte mode latches first byte, joins second.
// - Data drive only while addressed or during a trial strobe.
// - Byte mode loads on second byte write.
// - One channel is SAR trial source.
// - Each trial settles before comparator sample.
`timescale 1ns/1ps
module qdh_host (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic wr_in,
    input wire logic byte_mode_in,
    input wire logic left_just_in,
    input wire logic conv_start_in,
    input wire logic comp_high_in,
    output logic dac_one_select_n_out,
    output logic dac_two_select_n_out,
    output logic dac_three_select_n_out,
    output logic dac_four_select_n_out,
    output logic [11:0] dac_data_out,
    output logic dac_data_oe_out,
    output logic busy_out,
    output logic done_out,
    output logic [11:0] result_out
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Comparator high means the trial code lies above the unknown input, so the
    // bit under test is dropped; otherwise it stays set.
    function automatic logic [11:0] kept_trial(
        input logic [11:0] code,
        input logic [11:0] mask,
        input logic over
    );
        return over ? (code & ~mask) : code;
    endfunction : kept_trial
    // One-hot select for a channel number, bit 0 being the first DAC.
    function automatic logic [3:0] chan_bit(input logic [1:0] chan);
        return 4'h1 << chan;
    endfunction : chan_bit
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // The comparator and the start pin are not timed to this clock, so each
    // passes two flip-flops before any logic reads it. The start edge is taken
    // from the synchronised level; a slow or bouncing rise starts at most one
    // conversion, because a start that arrives while busy is ignored.
    logic comp_meta;
    logic comp_sync;
    logic start_meta;
    logic start_sync;
    logic start_prev;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_prev <= 1'b0;
        end else begin
            comp_meta <= comp_high_in;
            comp_sync <= comp_meta;
            start_meta <= conv_start_in;
            start_sync <= start_meta;
            start_prev <= start_sync;
        end
    end
    wire start_rise;
    assign start_rise = start_sync && !start_prev;
    // ------------------------------------------------------------------
    // Host bus decode and data placement
    // ------------------------------------------------------------------
    logic [3:0] bus_sel;
    logic bus_match;
    logic [11:0] bus_code;
    logic byte_phase;
    wire wr_rise;
    wire wr_end;
    logic wr_prev;
    logic hit_prev;
    // Address bit 0 is the lowest word-address bit, so every DAC has a word
    // address of its own and several bits set load several DACs at once.
    qdh_decode u_decode (
        .addr_in(addr_in),
        .wr_in(wr_in),
        .sel_out(bus_sel),
        .match_out(bus_match)
    );
    // The first byte of a pair only fills the holding latch, no select fires.
    wire first_byte;
    assign first_byte = byte_mode_in && wr_rise && bus_match && !byte_phase;
    qdh_pack u_pack (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .data_in(data_in),
        .byte_mode_in(byte_mode_in),
        .left_just_in(left_just_in),
        .first_byte_in(first_byte),
        .code_out(bus_code)
    );
    assign wr_rise = wr_in && !wr_prev;
    // A write ends one edge after the strobe drops, judged by the match seen
    // while it was still high, so a host that clears the address together with
    // the strobe still advances the byte phase.
    assign wr_end = hit_prev && !wr_in;
    // The byte phase flips when a matching write ends, so the select of the
    // second byte stands for the whole strobe; a select of one clock would be
    // far below the latch pulse width.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_prev <= 1'b0;
            hit_prev <= 1'b0;
            byte_phase <= 1'b0;
        end else begin
            wr_prev <= wr_in;
            hit_prev <= wr_in && bus_match;
            if (!byte_mode_in) begin
                byte_phase <= 1'b0;
            end else if (wr_end) begin
                byte_phase <= !byte_phase;
            end
        end
    end
    // SAR owns its channel during strobe and settle; the bus may still drive the other three during settle.
    wire [3:0] bus_sel_ok;
    wire bus_load;
    assign bus_sel_ok = (byte_mode_in && !byte_phase) ? 4'h0 : bus_sel;
    assign bus_load = |bus_sel_ok;
    // ------------------------------------------------------------------
    // Successive approximation sequencer
    // ------------------------------------------------------------------
    // Each bit costs the strobe count, then the settle count, then one decide
    // cycle. The settle count is the one to shorten when the comparator and its
    // clamp settle faster; the strobe count only has to cover the latch pulse.
    qdh_pkg::qdh_state_e state;
    qdh_pkg::qdh_state_e next_state;
    logic [11:0] trial;
    logic [11:0] bit_mask;
    logic [12:0] wait_cnt;
    logic [12:0] next_wait_cnt;
    logic [11:0] next_trial;
    logic [11:0] next_bit_mask;
    wire sar_active;
    assign sar_active = (state == qdh_pkg::QDH_STROBE) || (state == qdh_pkg::QDH_SETTLE);
    always_comb begin
        next_state = state;
        next_trial = trial;
        next_bit_mask = bit_mask;
        next_wait_cnt = wait_cnt;
        case (state)
            qdh_pkg::QDH_IDLE: begin
                if (start_rise) begin
                    next_state = qdh_pkg::QDH_STROBE;
                    next_bit_mask = 12'h800;
                    next_trial = 12'h800;
                    next_wait_cnt = 13'(qdh_pkg::SEL_PULSE_CYC);
                end
            end
            qdh_pkg::QDH_STROBE: begin
                if (wait_cnt == 13'h0001) begin
                    next_state = qdh_pkg::QDH_SETTLE;
                    next_wait_cnt = 13'(qdh_pkg::SETTLE_CYC);
                end else begin
                    next_wait_cnt = wait_cnt - 13'h0001;
                end
            end
            qdh_pkg::QDH_SETTLE: begin
                if (wait_cnt == 13'h0001) begin
                    next_state = qdh_pkg::QDH_DECIDE;
                end else begin
                    next_wait_cnt = wait_cnt - 13'h0001;
                end
            end
            qdh_pkg::QDH_DECIDE: begin
                next_trial = kept_trial(trial, bit_mask, comp_sync);
                next_bit_mask = bit_mask >> 1;
                if (bit_mask == 12'h001) begin
                    next_state = qdh_pkg::QDH_DONE;
                end else begin
                    // The next lower bit becomes the fresh trial.
                    next_state = qdh_pkg::QDH_STROBE;
                    next_trial = kept_trial(trial, bit_mask, comp_sync) | (bit_mask >> 1);
                    next_wait_cnt = 13'(qdh_pkg::SEL_PULSE_CYC);
                end
            end
            qdh_pkg::QDH_DONE: begin
                next_state = qdh_pkg::QDH_IDLE;
            end
            default: begin
                next_state = qdh_pkg::QDH_IDLE;
            end
        endcase
    end
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= qdh_pkg::QDH_IDLE;
            trial <= qdh_pkg::CODE_RST;
            bit_mask <= qdh_pkg::CODE_RST;
            wait_cnt <= 13'h0000;
        end else begin
            state <= next_state;
            trial <= next_trial;
            bit_mask <= next_bit_mask;
            wait_cnt <= next_wait_cnt;
        end
    end
    // ------------------------------------------------------------------
    // Pin outputs, all registered
    // ------------------------------------------------------------------
    // The trial strobe holds the select low only for the pulse width, so the
    // latch is closed again while the comparator settles.
    wire sar_strobe;
    wire [3:0] sar_sel;
    wire [3:0] bus_sel_free;
    wire [3:0] next_sel;
    wire [11:0] next_data;
    wire next_oe;
    assign sar_strobe = state == qdh_pkg::QDH_STROBE;
    assign sar_sel = sar_strobe ? chan_bit(qdh_pkg::SAR_CHAN) : 4'h0;
    assign bus_sel_free = sar_active ? (bus_sel_ok & ~chan_bit(qdh_pkg::SAR_CHAN)) : bus_sel_ok;
    // Bus loads that collide with a trial strobe are dropped to keep one data word.
    assign next_sel = sar_strobe ? sar_sel : bus_sel_free;
    assign next_data = sar_strobe ? trial : bus_code;
    // A select low always comes with the buffer on, so an open latch never
    // takes the pull-up level; the data word is held while the buffer is off.
    assign next_oe = sar_strobe || (bus_load && bus_match);
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dac_one_select_n_out <= 1'b1;
            dac_two_select_n_out <= 1'b1;
            dac_three_select_n_out <= 1'b1;
            dac_four_select_n_out <= 1'b1;
            dac_data_out <= qdh_pkg::CODE_RST;
            dac_data_oe_out <= 1'b0;
        end else begin
            dac_one_select_n_out <= !next_sel[0];
            dac_two_select_n_out <= !next_sel[1];
            dac_three_select_n_out <= !next_sel[2];
            dac_four_select_n_out <= !next_sel[3];
            dac_data_out <= next_oe ? next_data : dac_data_out;
            dac_data_oe_out <= next_oe;
        end
    end
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            result_out <= qdh_pkg::CODE_RST;
        end else begin
            // Taken from the next state so that busy and done line up with the
            // state register instead of trailing it by a clock.
            busy_out <= next_state != qdh_pkg::QDH_IDLE;
            done_out <= next_state == qdh_pkg::QDH_DONE;
            if (next_state == qdh_pkg::QDH_DONE) begin
                result_out <= next_trial;
            end
        end
    end
endmodule : qdh_host

// >>> hw/qdh_pack.sv
// Data placement from a 16-bit word or two successive bytes into a 12-bit code.
`timescale 1ns/1ps
module qdh_pack (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [15:0] data_in,
    input wire logic byte_mode_in,
    input wire logic left_just_in,
    input wire logic first_byte_in,
    output logic [11:0] code_out
);
    logic [7:0] low_byte;
    wire [11:0] word_code;
    wire [11:0] byte_code;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_byte <= 8'h00;
        end else if (first_byte_in) begin
            low_byte <= data_in[7:0];
        end
    end
    assign word_code = left_just_in ? data_in[15:qdh_pkg::LEFT_LSB] : data_in[11:0];
    assign byte_code = {data_in[3:0], low_byte};
    assign code_out = byte_mode_in ? byte_code : word_code;
endmodule : qdh_pack

// >>> hw/qdh_pkg.sv
// Package of constants and types for the quad DAC host interface.
package qdh_pkg;
    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int BUS_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int NUM_DAC = 4;
    localparam int CHAN_W = 2;
    localparam int SEL_LSB = 0;
    localparam int BASE_LSB = 4;
    localparam int LEFT_LSB = 4;
    localparam int HIGH_NIB_W = 4;
    localparam logic [11:0] BASE_ADDR = 12'h0c0;
    localparam logic [3:0] SEL_RST = 4'hf;
    localparam logic [11:0] CODE_RST = 12'h000;
    localparam logic [1:0] SAR_CHAN = 2'h0;
    // ------------------------------------------------------------------
    // Timing, at a 4 ns clock
    // ------------------------------------------------------------------
    localparam int CLK_PS = 4000;
    localparam int SEL_PULSE_NS = 400;
    localparam int SEL_PULSE_CYC = (SEL_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SETTLE_US = 15;
    localparam int SETTLE_CYC = (SETTLE_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 13;
    typedef enum logic [2:0] {
        QDH_IDLE, QDH_STROBE, QDH_SETTLE, QDH_DECIDE, QDH_DONE
    } qdh_state_e;
endpackage : qdh_pkg

// >>> sim/qdh_dac_model.sv
// Behavioural model of the four DAC latches, one output and the comparator.
`timescale 1ns/1ps
module qdh_dac_model #(
    parameter int REF_MV = 10000
) (
    input wire logic ref_clk_in,
    input wire logic [3:0] select_n_in,
    input wire logic [11:0] data_in,
    input wire logic oe_in,
    input wire logic [11:0] unknown_in,
    output logic [3:0][11:0] code_out,
    output logic comp_high_out,
    output int out_one_mv
);
    // Pull-ups hold the inputs high when nobody drives them.
    wire [11:0] bus = oe_in ? data_in : 12'hfff;
    // Sampling before the edge keeps the last word seen while the select was low.
    always @(posedge ref_clk_in) begin
        for (int k = 0; k < 4; k++) begin
            if (!select_n_in[k]) begin
                code_out[k] <= bus;
            end
        end
    end
    assign comp_high_out = code_out[0] > unknown_in;
    assign out_one_mv = -(REF_MV * int'(code_out[0])) / 4096;
endmodule : qdh_dac_model

// >>> sim/qdh_host_monitor.sv
// Checker of select, data and conversion timing at the host controller ports.
`timescale 1ns/1ps
module qdh_host_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic wr_in,
    input wire logic byte_mode_in,
    input wire logic left_just_in,
    input wire logic dac_one_select_n_out,
    input wire logic dac_two_select_n_out,
    input wire logic dac_three_select_n_out,
    input wire logic dac_four_select_n_out,
    input wire logic [11:0] dac_data_out,
    input wire logic dac_data_oe_out,
    input wire logic busy_out,
    input wire logic done_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [15:0] low_cnt;
    logic [15:0] busy_cnt;
    wire base_ok = addr_in[15:4] == qdh_pkg::BASE_ADDR;
    wire word_hit = wr_in && base_ok && !busy_out && !byte_mode_in;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_cnt <= 16'h0000;
            busy_cnt <= 16'h0000;
        end else begin
            low_cnt <= dac_one_select_n_out ? 16'h0000 : low_cnt + 16'h0001;
            busy_cnt <= busy_out ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end
    chk_sel_follows: assert property (word_hit && addr_in[2] |=> !dac_three_select_n_out)
        else $error("select three missed a decoded write");
    chk_sel_gated: assert property (!dac_two_select_n_out |->
        $past(wr_in) && $past(addr_in[15:4]) == qdh_pkg::BASE_ADDR && $past(addr_in[1]))
        else $error("select two low without a matching write");
    chk_sel_release: assert property (!wr_in |=>
        dac_two_select_n_out && dac_three_select_n_out && dac_four_select_n_out)
        else $error("select stayed low after the strobe ended");
    chk_right_code: assert property (word_hit && !left_just_in |=>
        dac_data_out == $past(data_in[11:0]))
        else $error("right justified code wrong");
    chk_left_code: assert property (word_hit && left_just_in |=>
        dac_data_out == $past(data_in[15:4]))
        else $error("left justified code wrong");
    chk_drive_addressed: assert property (dac_data_oe_out && !busy_out && !$past(busy_out) |->
        $past(wr_in) && $past(addr_in[15:4]) == qdh_pkg::BASE_ADDR)
        else $error("data driven while not addressed");
    chk_strobe_width: assert property ($rose(dac_one_select_n_out) && busy_out |->
        low_cnt == 16'h0064)
        else $error("trial strobe width wrong");
    chk_conv_length: assert property ($fell(busy_out) |->
        busy_cnt >= 16'hb478 && busy_cnt <= 16'hb496)
        else $error("conversion length wrong");
    chk_trial_only: assert property (!dac_one_select_n_out && !$past(wr_in) |->
        busy_out || $past(busy_out))
        else $error("trial channel selected outside a conversion");
    cov_done: cover property (done_out);
    cov_all_four: cover property (!dac_one_select_n_out && !dac_two_select_n_out
        && !dac_three_select_n_out && !dac_four_select_n_out);
    cov_byte_load: cover property (byte_mode_in && !dac_three_select_n_out);
endmodule : qdh_host_monitor
bind qdh_host qdh_host_monitor mon_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .data_in(data_in), .wr_in(wr_in), .byte_mode_in(byte_mode_in),
    .left_just_in(left_just_in), .dac_one_select_n_out(dac_one_select_n_out),
    .dac_two_select_n_out(dac_two_select_n_out), .dac_three_select_n_out(dac_three_select_n_out),
    .dac_four_select_n_out(dac_four_select_n_out), .dac_data_out(dac_data_out),
    .dac_data_oe_out(dac_data_oe_out), .busy_out(busy_out), .done_out(done_out));

// >>> sim/qdh_host_tb.sv
// Self-checking bench for the quad DAC host controller.
`timescale 1ns/1ps
module qdh_host_tb;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [15:0] data_in = 16'h0000;
    logic wr_in = 1'b0;
    logic byte_mode_in = 1'b0;
    logic left_just_in = 1'b0;
    logic conv_start_in = 1'b0;
    logic [11:0] unknown = 12'h000;
    logic [3:0] sel_n;
    logic [3:0] sel_prev = 4'hf;
    logic [3:0][11:0] code;
    logic [11:0] dac_data;
    logic [11:0] result;
    logic oe, busy, done, comp_high;
    logic [31:0] seed = 32'h000024eb;
    logic [14:0] notes[$];
    int bad_count = 0;
    int cmp_count = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    qdh_host dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .data_in(data_in), .wr_in(wr_in), .byte_mode_in(byte_mode_in),
        .left_just_in(left_just_in), .conv_start_in(conv_start_in), .comp_high_in(comp_high),
        .dac_one_select_n_out(sel_n[0]), .dac_two_select_n_out(sel_n[1]),
        .dac_three_select_n_out(sel_n[2]), .dac_four_select_n_out(sel_n[3]),
        .dac_data_out(dac_data), .dac_data_oe_out(oe), .busy_out(busy), .done_out(done),
        .result_out(result));
    qdh_dac_model model_u (.ref_clk_in(ref_clk_in), .select_n_in(sel_n), .data_in(dac_data),
        .oe_in(oe), .unknown_in(unknown), .code_out(code), .comp_high_out(comp_high),
        .out_one_mv());
    // Only the low half is handed out: every consumer is a 16-bit bus word.
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : xs
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Address and data stay one cycle past the strobe so the closing latch sees them.
    task automatic put(input logic [3:0] sel, input logic [15:0] d, input logic [11:0] base);
        @(negedge ref_clk_in);
        addr_in = {base, sel};
        data_in = d;
        wr_in = 1'b1;
        repeat (100) @(negedge ref_clk_in);
        wr_in = 1'b0;
        @(negedge ref_clk_in);
        addr_in = 16'h0000;
        data_in = xs();
    endtask : put
    // Each latch closing outside a conversion, and each done pulse, consumes one note.
    always @(negedge ref_clk_in) begin : watch
        logic [14:0] n;
        for (int k = 0; k < 5; k++) begin
            if (k < 4 ? (sel_n[k] && !sel_prev[k] && !busy) : done === 1'b1) begin
                n = notes.size() > 0 ? notes.pop_front() : 15'h7000;
                chk("channel", {9'h000, n[14:12]}, 12'(k));
                chk("code", n[11:0], k < 4 ? code[k] : result);
            end
        end
        sel_prev <= sel_n;
    end
    initial begin : main
        logic [15:0] d;
        logic [15:0] e;
        int i;
        repeat (12) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        for (int k = 0; k < 4; k++) begin
            d = xs();
            notes.push_back({3'(k), d[11:0]});
            put(4'h1 << k, d, qdh_pkg::BASE_ADDR);
        end
        left_just_in = 1'b1;
        d = xs();
        for (int k = 1; k < 3; k++) notes.push_back({3'(k), d[15:4]});
        put(4'h6, d, qdh_pkg::BASE_ADDR);
        d = xs();
        for (int k = 0; k < 4; k++) notes.push_back({3'(k), d[15:4]});
        put(4'hf, d, qdh_pkg::BASE_ADDR);
        put(4'hf, xs(), qdh_pkg::BASE_ADDR ^ 12'h001);
        byte_mode_in = 1'b1;
        left_just_in = 1'b0;
        d = xs();
        e = xs();
        put(4'h4, d, qdh_pkg::BASE_ADDR);
        notes.push_back({3'd2, e[3:0], d[7:0]});
        put(4'h4, e, qdh_pkg::BASE_ADDR);
        byte_mode_in = 1'b0;
        d = xs();
        unknown = d[11:0];
        notes.push_back({3'd4, d[11:0]});
        conv_start_in = 1'b1;
        i = 0;
        while (done !== 1'b1 && i < 50000) begin
            @(negedge ref_clk_in);
            conv_start_in = i < 10;
            i++;
        end
        if (i == 50000) begin
            bad_count++;
            conclude();
        end
        repeat (5) @(negedge ref_clk_in);
        chk("pending notes", 12'h000, 12'(notes.size()));
        conclude();
    end
endmodule : qdh_host_tb
